// >>> odfd_core.sv
/*
  Fault diagnostics of an eight-channel low-side driver with its serial
  port. Holds the command state, judges each channel, keeps the fault
  register and shifts it out while shifting a command word in.
  Assumes comparator levels, pins and the serial port are asynchronous
  to clk_sys and that clk_sys is much faster than the serial clock.
*/
`default_nettype none

module odfd_core #(
  parameter int           FILTER_TIME_NS  = 20000,    // Open/short filter
  parameter int           OVC_TIME_NS     = 10000,    // Overcurrent filter
  parameter int           RESTART_TIME_NS = 10000000, // Restart delay
  parameter int           CNT_W           = 24,       // Timer width
  parameter logic         CLEAR_ALL       = 1'b1      // 1: clear all at word
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Serial port
  input  wire logic       chip_select_n,
  input  wire logic       serial_clock,
  input  wire logic       serial_input,
  output var  logic       serial_output,
  // Analog comparator levels per channel
  input  wire logic [7:0] drain_between,
  input  wire logic [7:0] drain_below_gnd,
  input  wire logic [7:0] over_current,
  input  wire logic [7:0] thermal_shutdown,
  // Parallel inputs of channels six to eight
  input  wire logic [2:0] direct_drive_wire,
  // Driver gates and fault register view
  output var  logic [7:0] channel_drive,
  output var  logic [15:0] channel_fault_codes
);

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam int FILT_INT = (FILTER_TIME_NS + odfd_pkg::CLK_PERIOD_NS - 1)
                            / odfd_pkg::CLK_PERIOD_NS;
  localparam int OVC_INT  = (OVC_TIME_NS + odfd_pkg::CLK_PERIOD_NS - 1)
                            / odfd_pkg::CLK_PERIOD_NS;
  localparam int RES_INT  = (RESTART_TIME_NS + odfd_pkg::CLK_PERIOD_NS - 1)
                            / odfd_pkg::CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] FILT_LAST = CNT_W'((FILT_INT < 1) ? 0 :
                                                  FILT_INT - 1);
  localparam logic [CNT_W-1:0] OVC_LAST  = CNT_W'((OVC_INT < 1) ? 0 :
                                                  OVC_INT - 1);
  localparam logic [CNT_W-1:0] RES_LAST  = CNT_W'((RES_INT < 1) ? 0 :
                                                  RES_INT - 1);

  // Key match of a received word
  function automatic logic is_key(input logic [15:0] w,
                                  input logic [7:0]  k);
    is_key = (w[15:8] == k);
  endfunction

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  logic [2:0]  cs_sy, sck_sy, din_sy;       // Serial pins, two stages+edge
  logic [7:0]  btw_s1, btw_s2;              // Drain between thresholds
  logic [7:0]  low_s1, low_s2;              // Drain below ground threshold
  logic [7:0]  ovc_s1, ovc_s2;              // Current above threshold
  logic [7:0]  thr_s1, thr_s2;              // Thermal shutdown
  logic [2:0]  dd_s1, dd_s2, dd_q;          // Parallel inputs and history

  // Two flops on every asynchronous level before use
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cs_sy  <= 3'h7;
      sck_sy <= 3'h0;
      din_sy <= 3'h0;
      btw_s1 <= 8'h00;
      btw_s2 <= 8'h00;
      low_s1 <= 8'h00;
      low_s2 <= 8'h00;
      ovc_s1 <= 8'h00;
      ovc_s2 <= 8'h00;
      thr_s1 <= 8'h00;
      thr_s2 <= 8'h00;
      dd_s1  <= 3'h0;
      dd_s2  <= 3'h0;
      dd_q   <= 3'h0;
    end else begin
      cs_sy  <= {cs_sy[1:0], chip_select_n};
      sck_sy <= {sck_sy[1:0], serial_clock};
      din_sy <= {din_sy[1:0], serial_input};
      btw_s1 <= drain_between;
      btw_s2 <= btw_s1;
      low_s1 <= drain_below_gnd;
      low_s2 <= low_s1;
      ovc_s1 <= over_current;
      ovc_s2 <= ovc_s1;
      thr_s1 <= thermal_shutdown;
      thr_s2 <= thr_s1;
      dd_s1  <= direct_drive_wire;
      dd_s2  <= dd_s1;
      dd_q   <= dd_s2;
    end
  end

  // Edges seen on the synchronised serial pins
  logic cs_fall, cs_rise, sck_rise, sck_fall, active, thermal_any;
  assign cs_fall     = cs_sy[2] & ~cs_sy[1];
  assign cs_rise     = ~cs_sy[2] & cs_sy[1];
  assign active      = ~cs_sy[1];
  assign sck_rise    = active & ~sck_sy[2] & sck_sy[1];
  assign sck_fall    = active & sck_sy[2] & ~sck_sy[1];
  assign thermal_any = |thr_s2;

  // ****************************************************************
  // Serial shift register
  // ****************************************************************
  logic [15:0]               shift;         // Out data, then in data
  logic [odfd_pkg::BITCNT_W-1:0] bit_cnt;   // Bits received, saturating
  logic [15:0]               codes;         // Fault register
  logic [15:0]               next_codes;    // Fault register next value
  logic                      valid_word;    // Full word at select rise

  assign valid_word = cs_rise & (bit_cnt == odfd_pkg::WORD_BITS);

  // Load at select fall, shift in on rise, present on fall
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shift         <= odfd_pkg::FAULT_RESET;
      bit_cnt       <= '0;
      serial_output <= 1'b0;
    end else if (cs_fall) begin
      // Thermal image overrides the codes without storing it
      if (thermal_any) begin
        shift         <= odfd_pkg::THERMAL_IMAGE;
        serial_output <= 1'b1;
      end else begin
        shift         <= next_codes;
        serial_output <= next_codes[15];
      end
      bit_cnt <= '0;
    end else if (sck_rise) begin
      // Extra bits wrap through; the last sixteen form the word
      shift <= {shift[14:0], din_sy[2]};
      if (bit_cnt != odfd_pkg::WORD_BITS) begin
        bit_cnt <= bit_cnt + 1'b1;
      end
    end else if (sck_fall) begin
      serial_output <= shift[15];
    end
  end

  // ****************************************************************
  // Command state
  // ****************************************************************
  logic [7:0] out_cmd;      // Commanded output state
  logic [7:0] diag_latch;   // 1: latching diagnostics
  logic [7:0] linear_lim;   // 1: linear limiting, no trip
  logic [7:0] prev_zero;    // Last valid word wrote this output zero
  logic [7:0] spi_restart;  // Zero-then-one restart pulse

  assign spi_restart = (valid_word &&
                        is_key(shift, odfd_pkg::KEY_OUTPUT)) ?
                       (shift[7:0] & prev_zero) : 8'h00;

  // Decode valid words; partial words are ignored
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out_cmd    <= odfd_pkg::OUT_RESET;
      diag_latch <= odfd_pkg::DIAG_RESET;
      linear_lim <= odfd_pkg::PROT_RESET;
      prev_zero  <= 8'h00;
    end else if (valid_word) begin
      if (is_key(shift, odfd_pkg::KEY_OUTPUT)) begin
        out_cmd   <= shift[7:0];
        prev_zero <= ~shift[7:0];
      end else begin
        prev_zero <= 8'h00;
      end
      if (is_key(shift, odfd_pkg::KEY_DIAG)) begin
        diag_latch <= shift[7:0];
      end
      if (is_key(shift, odfd_pkg::KEY_PROTECT)) begin
        linear_lim <= shift[7:0];
      end
    end
  end

  // ****************************************************************
  // Per-channel filters, trip and restart
  // ****************************************************************
  logic [7:0] chan_input;   // Channel asked to be on
  logic [7:0] tripped;      // Switched off by overcurrent
  logic [7:0] open_ev;      // Latching open load event
  logic [7:0] short_ev;     // Latching short event
  logic [7:0] ovc_ev;       // Overcurrent trip event
  logic [7:0] res_expire;   // Restart delay reached

  for (genvar i = 0; i < odfd_pkg::NUM_CH; i++) begin : g_ch
    logic [CNT_W-1:0] open_cnt, short_cnt, ovc_cnt, res_cnt;
    logic open_c, short_c, ovc_c, pin_rise;

    if (i >= odfd_pkg::DIRECT_FIRST) begin : g_pin
      assign chan_input[i] = out_cmd[i] | dd_s2[i-odfd_pkg::DIRECT_FIRST];
      assign pin_rise      = dd_s2[i-odfd_pkg::DIRECT_FIRST] &
                             ~dd_q[i-odfd_pkg::DIRECT_FIRST];
    end else begin : g_nopin
      assign chan_input[i] = out_cmd[i];
      assign pin_rise      = 1'b0;
    end

    // Conditions that feed the filters
    assign open_c  = diag_latch[i] & ~channel_drive[i] & btw_s2[i];
    assign short_c = diag_latch[i] & ~channel_drive[i] & low_s2[i];
    assign ovc_c   = channel_drive[i] & ~linear_lim[i] & ovc_s2[i];
    assign open_ev[i]    = open_c & (open_cnt == FILT_LAST);
    assign short_ev[i]   = short_c & (short_cnt == FILT_LAST);
    assign ovc_ev[i]     = ovc_c & (ovc_cnt == OVC_LAST);
    assign res_expire[i] = tripped[i] & (res_cnt == RES_LAST);

    // Filter counters count while the condition stands
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        open_cnt  <= '0;
        short_cnt <= '0;
        ovc_cnt   <= '0;
      end else begin
        open_cnt  <= (open_c && open_cnt != FILT_LAST + 1'b1) ?
                     open_cnt + 1'b1 : (open_c ? open_cnt : '0);
        short_cnt <= (short_c && short_cnt != FILT_LAST + 1'b1) ?
                     short_cnt + 1'b1 : (short_c ? short_cnt : '0);
        ovc_cnt   <= (ovc_c && !ovc_ev[i]) ? ovc_cnt + 1'b1 : '0;
      end
    end

    // Trip, restart delay and gate drive
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        tripped[i]       <= 1'b0;
        res_cnt          <= '0;
        channel_drive[i] <= 1'b0;
      end else begin
        if (ovc_ev[i]) begin
          tripped[i] <= 1'b1;
        end else if (res_expire[i] || spi_restart[i] || pin_rise) begin
          tripped[i] <= 1'b0;
        end
        res_cnt <= (tripped[i] && !res_expire[i]) ? res_cnt + 1'b1 : '0;
        channel_drive[i] <= chan_input[i] & ~tripped[i] & ~ovc_ev[i];
      end
    end

    // Channel checks
    trip_off_a: assert property (@(posedge clk_sys) disable iff (reset)
      ovc_ev[i] |=> !channel_drive[i] && tripped[i])
      else $error("trip did not switch the channel off");
    linear_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
      linear_lim[i] |-> !ovc_ev[i])
      else $error("overcurrent reported under linear limiting");
    restart_delay_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      res_expire[i] && !ovc_ev[i] |=> !tripped[i])
      else $error("restart delay did not release the channel");
    latch_open_a: assert property (@(posedge clk_sys) disable iff (reset)
      open_ev[i] && !short_ev[i] && !ovc_ev[i] && !valid_word &&
      codes[2*i +: 2] != odfd_pkg::CODE_OVC
      |=> codes[2*i +: 2] == odfd_pkg::CODE_OPEN)
      else $error("latched open load not recorded");
    ovc_code_a: assert property (@(posedge clk_sys) disable iff (reset)
      ovc_ev[i] |=> codes[2*i +: 2] == odfd_pkg::CODE_OVC)
      else $error("overcurrent code not written");
  end

  // ****************************************************************
  // Fault register
  // ****************************************************************
  // Next codes: clear first, then events, so a new fault wins a clear
  always_comb begin
    logic [1:0] cur;
    cur        = odfd_pkg::CODE_NONE;
    next_codes = codes;
    for (int i = 0; i < odfd_pkg::NUM_CH; i++) begin
      cur = codes[2*i +: 2];
      if (valid_word && (CLEAR_ALL || cur != odfd_pkg::CODE_OVC)) begin
        cur = odfd_pkg::CODE_NONE;
      end
      if (!CLEAR_ALL && cur == odfd_pkg::CODE_OVC &&
          (res_expire[i] || !chan_input[i])) begin
        cur = odfd_pkg::CODE_NONE;
      end
      if (ovc_ev[i]) begin
        cur = odfd_pkg::CODE_OVC;
      end else if (cur != odfd_pkg::CODE_OVC) begin
        if (diag_latch[i]) begin
          // Latching: keep until the clear condition
          if (short_ev[i]) begin
            cur = odfd_pkg::CODE_SHORT;
          end else if (open_ev[i]) begin
            cur = odfd_pkg::CODE_OPEN;
          end
        end else if (cs_fall) begin
          // Non-latching: only the level at select fall counts
          if (channel_drive[i]) begin
            cur = odfd_pkg::CODE_NONE;
          end else if (low_s2[i]) begin
            cur = odfd_pkg::CODE_SHORT;
          end else if (btw_s2[i]) begin
            cur = odfd_pkg::CODE_OPEN;
          end else begin
            cur = odfd_pkg::CODE_NONE;
          end
        end
      end
      next_codes[2*i +: 2] = cur;
    end
  end

  // Register and its read-only view
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      codes               <= odfd_pkg::FAULT_RESET;
      channel_fault_codes <= odfd_pkg::FAULT_RESET;
    end else begin
      codes               <= next_codes;
      channel_fault_codes <= next_codes;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  thermal_image_a: assert property (cs_fall && thermal_any
    |=> shift == odfd_pkg::THERMAL_IMAGE && serial_output)
    else $error("thermal image not loaded at select fall");
  normal_image_a: assert property (cs_fall && !thermal_any
    |=> shift == $past(next_codes) && shift == codes)
    else $error("fault codes not loaded at select fall");
  clear_all_a: assert property (CLEAR_ALL && valid_word && !(|ovc_ev) &&
    !(|open_ev) && !(|short_ev) |=> codes == odfd_pkg::FAULT_RESET)
    else $error("valid word did not clear the faults");
  ovc_hold_a: assert property (codes[1:0] == odfd_pkg::CODE_OVC &&
    CLEAR_ALL && !valid_word |=> codes[1:0] == odfd_pkg::CODE_OVC)
    else $error("overcurrent code lost without a clear");
  diag_cmd_a: assert property (valid_word &&
    shift[15:8] == odfd_pkg::KEY_DIAG |=> diag_latch == $past(shift[7:0]))
    else $error("diagnostic mode word not applied");
  prot_cmd_a: assert property (valid_word &&
    shift[15:8] == odfd_pkg::KEY_PROTECT
    |=> linear_lim == $past(shift[7:0]))
    else $error("protection word not applied");
  shift_out_a: assert property (sck_fall && !cs_fall
    |=> serial_output == $past(shift[15]))
    else $error("serial output not updated on clock fall");
  nolatch_short_a: assert property (cs_fall && !diag_latch[0] &&
    !channel_drive[0] && low_s2[0] && !ovc_ev[0] &&
    codes[1:0] != odfd_pkg::CODE_OVC
    |=> codes[1:0] == odfd_pkg::CODE_SHORT)
    else $error("sampled short not recorded");

  word_c:    cover property (valid_word);
  trip_c:    cover property (|ovc_ev);
  thermal_c: cover property (cs_fall && thermal_any);
  restart_c: cover property (|spi_restart);

endmodule // odfd_core

`default_nettype wire

// >>> odfd_core_bench.sv
/*
  Self-checking bench of odfd_core with a serial host model.
  Assumes short filter and restart times set by parameter.
*/
`default_nettype none

module odfd_core_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys, reset, chip_select_n, serial_clock;
  logic        serial_input, serial_output;
  logic [7:0]  drain_between, drain_below_gnd, over_current;
  logic [7:0]  thermal_shutdown, channel_drive;
  logic [2:0]  direct_drive_wire;
  logic [15:0] channel_fault_codes, rd;
  logic [7:0]  channel_drive_b;             // Second variant gate drive
  logic [15:0] codes_b;                     // Second variant fault codes
  int          errors, n_compared, seed;

  // Filter 10, overcurrent 10, restart 1000 cycles
  odfd_core #(.FILTER_TIME_NS(400), .OVC_TIME_NS(400),
    .RESTART_TIME_NS(40000)) dut (.clk_sys(clk_sys), .reset(reset),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .serial_input(serial_input), .serial_output(serial_output),
    .drain_between(drain_between), .drain_below_gnd(drain_below_gnd),
    .over_current(over_current), .thermal_shutdown(thermal_shutdown),
    .direct_drive_wire(direct_drive_wire),
    .channel_drive(channel_drive),
    .channel_fault_codes(channel_fault_codes));

  // Second variant: overcurrent clears on restart, shares all inputs
  odfd_core #(.FILTER_TIME_NS(400), .OVC_TIME_NS(400),
    .RESTART_TIME_NS(40000), .CLEAR_ALL(1'b0)) dut_b (.clk_sys(clk_sys),
    .reset(reset), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .serial_input(serial_input),
    .serial_output(), .drain_between(drain_between),
    .drain_below_gnd(drain_below_gnd), .over_current(over_current),
    .thermal_shutdown(thermal_shutdown),
    .direct_drive_wire(direct_drive_wire),
    .channel_drive(channel_drive_b),
    .channel_fault_codes(codes_b));

  odfd_host u_host (.clk_sys(clk_sys), .serial_output(serial_output),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .serial_input(serial_input));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Comparison with counting
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bounded wait for a gate level
  task automatic wait_drive(input int ch, input logic lvl, input int lim);
    int n;
    n = 0;
    while (channel_drive[ch] !== lvl && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    check({15'h0000, channel_drive[ch]}, {15'h0000, lvl});
    if (n >= lim) report_and_stop();
  endtask

  // Expected sampled codes: short wins over open
  function automatic logic [15:0] nl_codes(input logic [7:0] bt,
                                           input logic [7:0] bl);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < 8; i++)
      c[2*i +: 2] = bl[i] ? odfd_pkg::CODE_SHORT :
                    bt[i] ? odfd_pkg::CODE_OPEN : odfd_pkg::CODE_NONE;
    return c;
  endfunction

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    report_and_stop();
  end

  initial begin
    seed = 32'h53ec;
    reset = 1'b1;
    {drain_between, drain_below_gnd, over_current} = 24'h000000;
    thermal_shutdown = 8'h00;
    direct_drive_wire = 3'h0;
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    check(channel_fault_codes, odfd_pkg::FAULT_RESET);
    repeat (4) @(negedge clk_sys);
    u_host.xfer(16'h0000, rd);
    check(rd, odfd_pkg::FAULT_RESET);
    for (int k = 0; k < 7; k++) begin
      {drain_between, drain_below_gnd} = (k == 6) ? 16'h0000 :
                                         16'($random(seed));
      repeat (4) @(negedge clk_sys);
      // Upper byte zero: never a key, so modes and outputs stay put
      u_host.xfer({8'h00, 8'($random(seed))}, rd);
      check(rd, nl_codes(drain_between, drain_below_gnd));
    end
    drain_between = 8'h0f;
    thermal_shutdown = 8'h10;
    repeat (4) @(negedge clk_sys);
    u_host.xfer(16'h0000, rd);
    check(rd, odfd_pkg::THERMAL_IMAGE);
    thermal_shutdown = 8'h00;
    repeat (4) @(negedge clk_sys);
    u_host.xfer(16'h0000, rd);
    check(rd, 16'h0055);
    // Latch on channels 1-4 only; channel 3 sees a short glitch
    u_host.xfer({odfd_pkg::KEY_DIAG, 8'h0f}, rd);
    {drain_between, drain_below_gnd} = 16'h1102;
    repeat (14) @(negedge clk_sys);
    {drain_between, drain_below_gnd} = 16'h0400;
    repeat (5) @(negedge clk_sys);
    drain_between = 8'h00;
    repeat (4) @(negedge clk_sys);
    check(channel_fault_codes, 16'h0009);
    u_host.xfer(16'h0000, rd);
    check(rd, 16'h0009);
    check(channel_fault_codes, 16'h0000);
    // Overcurrent trip on channel 1 with open condition after trip
    u_host.xfer({odfd_pkg::KEY_OUTPUT, 8'h01}, rd);
    wait_drive(0, 1'b1, 10);
    {over_current, drain_between} = 16'h0101;
    wait_drive(0, 1'b0, 20);
    over_current = 8'h00;
    repeat (14) @(negedge clk_sys);
    check(channel_fault_codes, 16'h0003);
    check(codes_b, 16'h0003);
    wait_drive(0, 1'b1, 1050);
    drain_between = 8'h00;
    check(channel_fault_codes, 16'h0003);
    check(codes_b, 16'h0000);
    over_current = 8'h01;
    wait_drive(0, 1'b0, 20);
    over_current = 8'h00;
    u_host.xfer({odfd_pkg::KEY_OUTPUT, 8'h00}, rd);
    u_host.xfer({odfd_pkg::KEY_OUTPUT, 8'h01}, rd);
    check({15'h0000, channel_drive[0]}, 16'h0001);
    // Pin restart of channel six
    direct_drive_wire = 3'h1;
    wait_drive(5, 1'b1, 10);
    over_current = 8'h20;
    wait_drive(5, 1'b0, 20);
    {over_current, direct_drive_wire} = 11'h000;
    repeat (6) @(negedge clk_sys);
    direct_drive_wire = 3'h1;
    wait_drive(5, 1'b1, 10);
    // Linear limiting: no trip and no code
    u_host.xfer({odfd_pkg::KEY_PROTECT, 8'h01}, rd);
    over_current = 8'h01;
    repeat (25) @(negedge clk_sys);
    check({15'h0000, channel_drive[0]}, 16'h0001);
    check(channel_fault_codes, 16'h0000);
    report_and_stop();
  end
endmodule // odfd_core_bench

`default_nettype wire

// >>> odfd_host.sv
/*
  Serial host model for the fault diagnostics block: frames one
  16-bit word per call, MSB first, and returns what came back.
  Assumes clk_sys runs at 40 ns; serial clock period is 8 cycles.
*/
`default_nettype none

module odfd_host (
  // System clock and returned data
  input  wire logic clk_sys,
  input  wire logic serial_output,
  // Serial port towards the device
  output var  logic chip_select_n,
  output var  logic serial_clock,
  output var  logic serial_input
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Idle levels
  // ****************************************
  initial begin
    chip_select_n = 1'b1;
    serial_clock  = 1'b0;
    serial_input  = 1'b0;
  end

  // Data line toggles between frames so a stale bit is never read
  always @(negedge clk_sys) begin
    if (chip_select_n) serial_input <= ~serial_input;
  end

  // One framed word; clock idles low at select fall
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    @(negedge clk_sys);
    chip_select_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int i = 15; i >= 0; i--) begin
      serial_input = w[i];
      repeat (4) @(negedge clk_sys);
      r[i] = serial_output;
      serial_clock = 1'b1;
      repeat (4) @(negedge clk_sys);
      serial_clock = 1'b0;
    end
    repeat (4) @(negedge clk_sys);
    chip_select_n = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule // odfd_host

`default_nettype wire

// >>> odfd_pkg.sv
/*
  Constants shared by the octal driver fault diagnostics block: clock
  rate, register width, fault codes, command keys and reset values.
  Assumes a single system clock at the rate given below.
*/
`default_nettype none

package odfd_pkg;

  // ****************************************************************
  // Clock and sizes
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;          // System clock period
  localparam int NUM_CH        = 8;           // Output channels
  localparam int REG_W         = 16;          // Fault register width
  localparam int CODE_W        = 2;           // Bits per channel
  localparam int BITCNT_W      = 5;           // Serial bit counter width
  localparam int KEY_LSB       = 8;           // Key byte position
  localparam int DIRECT_FIRST  = 5;           // Index of first pin channel
  localparam int NUM_DIRECT    = 3;           // Channels with a pin input

  // ****************************************************************
  // Fault codes, high bit then low bit
  // ****************************************************************
  localparam logic [1:0] CODE_NONE  = 2'h0;   // No fault
  localparam logic [1:0] CODE_OPEN  = 2'h1;   // Open load
  localparam logic [1:0] CODE_SHORT = 2'h2;   // Short to ground
  localparam logic [1:0] CODE_OVC   = 2'h3;   // Overcurrent

  // ****************************************************************
  // Register images and reset values
  // ****************************************************************
  localparam logic [15:0] FAULT_RESET   = 16'h0000; // Cleared at power-on
  localparam logic [15:0] THERMAL_IMAGE = 16'hffff; // Any thermal fault
  localparam logic [4:0]  WORD_BITS     = 5'h10;    // Bits in a full word
  localparam logic [7:0]  OUT_RESET     = 8'h00;    // Outputs off
  localparam logic [7:0]  DIAG_RESET    = 8'h00;    // Non-latching
  localparam logic [7:0]  PROT_RESET    = 8'h00;    // Switch-off protection

  // ****************************************************************
  // Command keys in the upper byte
  // ****************************************************************
  localparam logic [7:0] KEY_OUTPUT  = 8'hac; // Output state word
  localparam logic [7:0] KEY_DIAG    = 8'ha3; // Diagnostic mode word
  localparam logic [7:0] KEY_PROTECT = 8'haa; // Protection mode word

endpackage

`default_nettype wire
